// [verilog/pcr_regs.sv]
// Peripheral control register bank: serial timing, hsync gate, display control,
// pin-level mirrors and stack pointer, with a small sticky interrupt block.
// Assumes a single 250 MHz clock, synchronous active-high reset, and asynchronous pins.
//
// Functional notes
// - Serial irq condition: clk7, clk8, start+7, stop
// - Shift clock: 100k, 200k, 500k, 1M
// - Serial registers survive STOP and CE resets
// - Gate code: close, open, 1.69 ms window
// - Gate status bit reads open state, rest zero
// - Transfer permit is bit 1, others zero
// - Transfer permit enables display and transfer mode
// - Bank bit selects character ROM bank 0/1
// - Display bit zero means on, one off
// - Bit 0 at 07H mirrors CE pin
// - Bit 2 at 0FH mirrors vsync pin
// - Register 01H holds the stack pointer
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

module pcr_regs #(
  parameter int unsigned GATE_CYCLES = pcr_pkg::GATE_WIN_CYC,
  parameter int unsigned SP_W        = 3
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        stop_rst,
  input  wire logic        ce_rst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [3:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [3:0]  reg_rdata,
  input  wire logic        ce_pin,
  input  wire logic        vsync_pin,
  input  wire logic        ser_clk_tick,
  input  wire logic        ser_start_cond,
  input  wire logic        ser_stop_cond,
  output logic             serial_irq,
  output logic             shift_clk,
  output logic             hsync_gate_open,
  output logic             display_transfer_mode,
  output logic             onscreen_display_enable,
  output logic             char_rom_bank_bit,
  output logic [SP_W-1:0]  stack_ptr,
  output logic             irq
);

  localparam int unsigned GW = $clog2(GATE_CYCLES + 1);

  // Any of the three resets clears the control registers and gate timer; power-on alone clears the rest, except serial setup and pin synchronisers (no reset)
  wire any_rst = rst | stop_rst | ce_rst;

  // Pin synchronisers
  logic [1:0] ce_sync_reg;
  logic [1:0] vs_sync_reg;
  logic       ce_prev_reg;
  logic       vs_prev_reg;

  always_ff @(posedge core_clk) begin
    ce_sync_reg <= {ce_sync_reg[0], ce_pin};
    vs_sync_reg <= {vs_sync_reg[0], vsync_pin};
    ce_prev_reg <= ce_sync_reg[1];
    vs_prev_reg <= vs_sync_reg[1];
  end

  wire ce_level = ce_sync_reg[1];
  wire vs_level = vs_sync_reg[1];

  // Register storage
  logic            xfer_permit_reg;
  logic            character_rom_bank_reg;
  logic            disp_off_reg;
  logic [1:0]      gate_code_reg;
  logic [1:0]      irq_cond_reg;
  logic [1:0]      clk_sel_reg;
  logic [SP_W-1:0] sp_reg;
  logic [3:0]      irq_status_reg;
  logic [3:0]      irq_mask_reg;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    return a == off;
  endfunction

  wire wr_xfer  = reg_wr & hit(reg_addr, pcr_pkg::OFF_XFER_EN);
  wire wr_sp    = reg_wr & hit(reg_addr, pcr_pkg::OFF_STACK_PTR);
  wire wr_gate  = reg_wr & hit(reg_addr, pcr_pkg::OFF_HS_GATE_CTL);
  wire wr_character_rom  = reg_wr & hit(reg_addr, pcr_pkg::OFF_CHARACTER_ROM_BANK);
  wire wr_disp  = reg_wr & hit(reg_addr, pcr_pkg::OFF_DISP_ONOFF);
  wire wr_irqc  = reg_wr & hit(reg_addr, pcr_pkg::OFF_SER_IRQ_TIM);
  wire wr_clks  = reg_wr & hit(reg_addr, pcr_pkg::OFF_SER_CLK_SEL);
  wire wr_ists  = reg_wr & hit(reg_addr, pcr_pkg::OFF_IRQ_STATUS);
  wire wr_imsk  = reg_wr & hit(reg_addr, pcr_pkg::OFF_IRQ_MASK);

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      xfer_permit_reg <= 1'b0;
      character_rom_bank_reg   <= 1'b0;
      disp_off_reg    <= 1'b0;
      gate_code_reg   <= pcr_pkg::PCR_GATE_CLOSE;
    end else begin
      if (wr_xfer) xfer_permit_reg <= reg_wdata[pcr_pkg::BIT_XFER_PERMIT];
      if (wr_character_rom) character_rom_bank_reg <= reg_wdata[pcr_pkg::BIT_CHARACTER_ROM_BANK];
      if (wr_disp) disp_off_reg <= reg_wdata[pcr_pkg::BIT_DISP_ONOFF];
      if (wr_gate) gate_code_reg <= reg_wdata[1:0];
    end
  end

  // Serial setup has no reset; power-on value is left undefined on purpose
  always_ff @(posedge core_clk) begin
    if (wr_irqc) irq_cond_reg <= reg_wdata[1:0];
    if (wr_clks) clk_sel_reg <= reg_wdata[1:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sp_reg       <= '0;
      irq_mask_reg <= pcr_pkg::RST_ZERO;
    end else begin
      if (wr_sp) sp_reg <= reg_wdata[SP_W-1:0];
      if (wr_imsk) irq_mask_reg <= reg_wdata;
    end
  end

  // Hsync gate: timed window counter
  logic [GW-1:0] gate_cnt_reg;
  logic          gate_open_reg;
  wire           gate_start = wr_gate & (reg_wdata[1:0] == pcr_pkg::PCR_GATE_TIMED);
  wire           gate_done  = (gate_code_reg == pcr_pkg::PCR_GATE_TIMED) & gate_open_reg &
                              (gate_cnt_reg == GW'(1));
  logic          gate_open_next;

  always_comb begin
    case (pcr_pkg::pcr_gate_e'(gate_code_reg))
      pcr_pkg::PCR_GATE_CLOSE: gate_open_next = 1'b0;
      pcr_pkg::PCR_GATE_OPEN:  gate_open_next = 1'b1;
      pcr_pkg::PCR_GATE_TIMED: gate_open_next = gate_cnt_reg != '0;
      default:                 gate_open_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      gate_cnt_reg  <= '0;
      gate_open_reg <= 1'b0;
    end else begin
      if (gate_start) gate_cnt_reg <= GW'(GATE_CYCLES);
      else if (gate_cnt_reg != '0) gate_cnt_reg <= gate_cnt_reg - GW'(1);
      gate_open_reg <= gate_start ? 1'b0 : gate_open_next;
    end
  end

  // Serial interrupt condition
  logic [3:0] sclk_cnt_reg;
  logic       after_start_reg;
  logic       ser_irq_reg;
  wire [3:0]  sclk_cnt_inc = sclk_cnt_reg + 4'h1;
  logic       ser_hit;

  always_comb begin
    case (pcr_pkg::pcr_irqc_e'(irq_cond_reg))
      pcr_pkg::PCR_IRQ_CLK7:  ser_hit = ser_clk_tick & (sclk_cnt_inc == 4'(pcr_pkg::CLK7_COUNT));
      pcr_pkg::PCR_IRQ_CLK8:  ser_hit = ser_clk_tick & (sclk_cnt_inc == 4'(pcr_pkg::CLK8_COUNT));
      pcr_pkg::PCR_IRQ_START: ser_hit = ser_clk_tick & after_start_reg &
                                        (sclk_cnt_inc == 4'(pcr_pkg::CLK7_COUNT));
      pcr_pkg::PCR_IRQ_STOP:  ser_hit = ser_stop_cond;
      default:                ser_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst | ser_start_cond | ser_stop_cond) begin
      sclk_cnt_reg <= '0;
    end else if (ser_clk_tick) begin
      sclk_cnt_reg <= (sclk_cnt_reg == 4'(pcr_pkg::CLK8_COUNT)) ? 4'h1 : sclk_cnt_inc;
    end
    if (rst | ser_stop_cond) after_start_reg <= 1'b0;
    else if (ser_start_cond) after_start_reg <= 1'b1;
    ser_irq_reg <= rst ? 1'b0 : ser_hit;
  end

  // Shift clock divider
  logic [15:0] div_cnt_reg;
  logic        shift_clk_reg;
  logic [15:0] half_div;

  always_comb begin
    case (clk_sel_reg)
      2'b00:   half_div = 16'(pcr_pkg::HALF_DIV_0);
      2'b01:   half_div = 16'(pcr_pkg::HALF_DIV_1);
      2'b10:   half_div = 16'(pcr_pkg::HALF_DIV_2);
      2'b11:   half_div = 16'(pcr_pkg::HALF_DIV_3);
      default: half_div = 16'(pcr_pkg::HALF_DIV_0);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt_reg   <= '0;
      shift_clk_reg <= 1'b0;
    end else if (div_cnt_reg >= half_div - 16'h1) begin
      div_cnt_reg   <= '0;
      shift_clk_reg <= ~shift_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h1;
    end
  end

  // Sticky interrupts: set wins over write-one-to-clear
  wire [3:0] irq_events;
  assign irq_events[pcr_pkg::IRQ_GATE_DONE] = gate_done;
  assign irq_events[pcr_pkg::IRQ_CE_CHANGE] = ce_level ^ ce_prev_reg;
  assign irq_events[pcr_pkg::IRQ_VS_CHANGE] = vs_level ^ vs_prev_reg;
  assign irq_events[pcr_pkg::IRQ_BAD_GATE]  = wr_gate & (reg_wdata[1:0] == pcr_pkg::PCR_GATE_BAD);
  wire [3:0] irq_clear = wr_ists ? reg_wdata : 4'h0;
  logic      irq_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status_reg <= pcr_pkg::RST_ZERO;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      irq_reg        <= |(((irq_status_reg & ~irq_clear) | irq_events) & irq_mask_reg);
    end
  end

  // Read mux
  logic [3:0] rd_mux;
  always_comb begin
    rd_mux = 4'h0;
    case (reg_addr)
      pcr_pkg::OFF_XFER_EN:     rd_mux[pcr_pkg::BIT_XFER_PERMIT] = xfer_permit_reg;
      pcr_pkg::OFF_STACK_PTR:   rd_mux[SP_W-1:0] = sp_reg;
      pcr_pkg::OFF_CE_LEVEL:    rd_mux[pcr_pkg::BIT_CE_LEVEL] = ce_level;
      pcr_pkg::OFF_VSYNC_LEVEL: rd_mux[pcr_pkg::BIT_VSYNC_LEVEL] = vs_level;
      pcr_pkg::OFF_HS_GATE_CTL: rd_mux[1:0] = gate_code_reg;
      pcr_pkg::OFF_HS_GATE_STS: rd_mux[pcr_pkg::BIT_GATE_OPEN] = gate_open_reg;
      pcr_pkg::OFF_CHARACTER_ROM_BANK:   rd_mux[pcr_pkg::BIT_CHARACTER_ROM_BANK] = character_rom_bank_reg;
      pcr_pkg::OFF_DISP_ONOFF:  rd_mux[pcr_pkg::BIT_DISP_ONOFF] = disp_off_reg;
      pcr_pkg::OFF_SER_IRQ_TIM: rd_mux[1:0] = irq_cond_reg;
      pcr_pkg::OFF_SER_CLK_SEL: rd_mux[1:0] = clk_sel_reg;
      pcr_pkg::OFF_IRQ_STATUS:  rd_mux = irq_status_reg;
      pcr_pkg::OFF_IRQ_MASK:    rd_mux = irq_mask_reg;
      default:                  rd_mux = 4'h0;
    endcase
  end

  logic [3:0] rdata_reg;
  logic       xfer_mode_reg;
  logic       disp_en_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg     <= 4'h0;
      xfer_mode_reg <= 1'b0;
      disp_en_reg   <= 1'b0;
    end else begin
      rdata_reg     <= reg_rd ? rd_mux : 4'h0;
      xfer_mode_reg <= xfer_permit_reg;
      // Display runs only when transfer is permitted and the on/off bit says on
      disp_en_reg   <= xfer_permit_reg & ~disp_off_reg;
    end
  end

  assign reg_rdata               = rdata_reg;
  assign serial_irq              = ser_irq_reg;
  assign shift_clk               = shift_clk_reg;
  assign hsync_gate_open         = gate_open_reg;
  assign display_transfer_mode   = xfer_mode_reg;
  assign onscreen_display_enable = disp_en_reg;
  assign char_rom_bank_bit       = character_rom_bank_reg;
  assign stack_ptr               = sp_reg;
  assign irq                     = irq_reg;

  // Assertions
  sequence timed_write_s;
    wr_gate && reg_wdata[1:0] == pcr_pkg::PCR_GATE_TIMED;
  endsequence

  gate_closed_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    gate_code_reg == pcr_pkg::PCR_GATE_CLOSE && !gate_start |=> !gate_open_reg)
    else $error("gate open while closed");
  gate_timed_opens_a: assert property (@(posedge core_clk) disable iff (any_rst)
    timed_write_s ##1 !any_rst |=> gate_open_reg)
    else $error("timed gate did not open");
  xfer_mode_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(xfer_permit_reg) |=> display_transfer_mode)
    else $error("transfer mode not entered");
  disp_off_a: assert property (@(posedge core_clk) disable iff (rst)
    disp_off_reg |=> !onscreen_display_enable)
    else $error("display on while off");
  ce_mirror_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_CE_LEVEL |=> reg_rdata == {3'b000, $past(ce_level)})
    else $error("ce mirror wrong");
  vs_mirror_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_VSYNC_LEVEL |=> reg_rdata[pcr_pkg::BIT_VSYNC_LEVEL] == $past(vs_level))
    else $error("vsync mirror wrong");
  status_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_HS_GATE_STS |=> reg_rdata[3:1] == 3'b000)
    else $error("status high bits set");
  fixed_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_XFER_EN |=> reg_rdata[3:2] == 2'b00 && !reg_rdata[0])
    else $error("fixed bits not zero");
  serial_keep_a: assert property (@(posedge core_clk)
    (stop_rst || ce_rst) && !wr_clks |=> clk_sel_reg == $past(clk_sel_reg))
    else $error("serial clock select lost");
  stop_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_cond_reg == pcr_pkg::PCR_IRQ_STOP && ser_stop_cond |=> serial_irq)
    else $error("stop irq missing");
  sp_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_sp |=> stack_ptr == $past(reg_wdata[SP_W-1:0]))
    else $error("stack pointer not written");

  sequence clk7_tick_s;
    irq_cond_reg == pcr_pkg::PCR_IRQ_CLK7 && ser_clk_tick && sclk_cnt_reg == 4'(pcr_pkg::CLK7_COUNT - 1);
  endsequence

  sequence clk8_tick_s;
    irq_cond_reg == pcr_pkg::PCR_IRQ_CLK8 && ser_clk_tick && sclk_cnt_reg == 4'(pcr_pkg::CLK8_COUNT - 1);
  endsequence

  xfer_write_a: assert property (@(posedge core_clk) disable iff (any_rst)
    wr_xfer |=> xfer_permit_reg == $past(reg_wdata[pcr_pkg::BIT_XFER_PERMIT]))
    else $error("transfer permit not written");
  bank_write_a: assert property (@(posedge core_clk) disable iff (any_rst)
    wr_character_rom |=> char_rom_bank_bit == $past(reg_wdata[pcr_pkg::BIT_CHARACTER_ROM_BANK]))
    else $error("bank bit not written");
  disp_write_a: assert property (@(posedge core_clk) disable iff (any_rst)
    wr_disp |=> disp_off_reg == $past(reg_wdata[pcr_pkg::BIT_DISP_ONOFF]))
    else $error("display bit not written");
  disp_needs_xfer_a: assert property (@(posedge core_clk) disable iff (rst)
    !xfer_permit_reg |=> !onscreen_display_enable)
    else $error("display on without transfer permit");
  xfer_mode_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(xfer_permit_reg) |=> !display_transfer_mode)
    else $error("transfer mode not left");
  irq_cond_keep_a: assert property (@(posedge core_clk)
    (stop_rst || ce_rst) && !wr_irqc |=> irq_cond_reg == $past(irq_cond_reg))
    else $error("serial irq condition lost");
  ctl_stop_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    stop_rst || ce_rst |=> !xfer_permit_reg && !character_rom_bank_reg && !disp_off_reg &&
    gate_code_reg == pcr_pkg::PCR_GATE_CLOSE)
    else $error("control registers not cleared");
  gate_bad_closed_a: assert property (@(posedge core_clk) disable iff (any_rst)
    gate_code_reg == pcr_pkg::PCR_GATE_BAD |=> !gate_open_reg)
    else $error("gate open on forbidden code");
  gate_open_hold_a: assert property (@(posedge core_clk) disable iff (any_rst)
    gate_code_reg == pcr_pkg::PCR_GATE_OPEN && !gate_start |=> gate_open_reg)
    else $error("gate not held open");
  gate_window_end_a: assert property (@(posedge core_clk) disable iff (any_rst)
    gate_code_reg == pcr_pkg::PCR_GATE_TIMED && gate_cnt_reg == '0 && !gate_start |=> !gate_open_reg)
    else $error("timed gate did not close");
  gate_window_hold_a: assert property (@(posedge core_clk) disable iff (any_rst)
    gate_code_reg == pcr_pkg::PCR_GATE_TIMED && gate_cnt_reg != '0 && !gate_start |=> gate_open_reg)
    else $error("timed gate closed early");
  status_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_HS_GATE_STS |=> reg_rdata[pcr_pkg::BIT_GATE_OPEN] == $past(hsync_gate_open))
    else $error("gate status read wrong");
  xfer_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_XFER_EN |=> reg_rdata[pcr_pkg::BIT_XFER_PERMIT] == $past(xfer_permit_reg))
    else $error("transfer permit read wrong");
  bank_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_CHARACTER_ROM_BANK |=> reg_rdata == {2'b00, $past(character_rom_bank_reg), 1'b0})
    else $error("bank register read wrong");
  disp_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == pcr_pkg::OFF_DISP_ONOFF |=> reg_rdata[3:1] == 3'b000)
    else $error("display register fixed bits set");
  sp_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !wr_sp |=> stack_ptr == $past(stack_ptr))
    else $error("stack pointer changed without write");
  clk7_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    clk7_tick_s |=> serial_irq)
    else $error("7th clock irq missing");
  clk8_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    clk8_tick_s |=> serial_irq)
    else $error("8th clock irq missing");
  start_wait_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_cond_reg == pcr_pkg::PCR_IRQ_START && !after_start_reg |=> !serial_irq)
    else $error("irq before start condition");
  stop_only_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_cond_reg == pcr_pkg::PCR_IRQ_STOP && !ser_stop_cond |=> !serial_irq)
    else $error("irq without stop condition");

endmodule

// [include/pcr_pkg.sv]
// Package for the peripheral control register bank: offsets, fields, codes, timing.
// Assumes a 250 MHz core clock and a 6-bit register address space of 4-bit registers.
package pcr_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 4;

  // Register offsets
  localparam logic [5:0] OFF_XFER_EN     = 6'h00;
  localparam logic [5:0] OFF_STACK_PTR   = 6'h01;
  localparam logic [5:0] OFF_CE_LEVEL    = 6'h07;
  localparam logic [5:0] OFF_VSYNC_LEVEL = 6'h0F;
  localparam logic [5:0] OFF_HS_GATE_CTL = 6'h11;
  localparam logic [5:0] OFF_HS_GATE_STS = 6'h12;
  localparam logic [5:0] OFF_CHARACTER_ROM_BANK   = 6'h30;
  localparam logic [5:0] OFF_DISP_ONOFF  = 6'h31;
  localparam logic [5:0] OFF_SER_IRQ_TIM = 6'h38;
  localparam logic [5:0] OFF_SER_CLK_SEL = 6'h39;
  localparam logic [5:0] OFF_IRQ_STATUS  = 6'h3C;
  localparam logic [5:0] OFF_IRQ_MASK    = 6'h3D;

  // Field positions
  localparam int unsigned BIT_XFER_PERMIT = 1;
  localparam int unsigned BIT_CHARACTER_ROM_BANK   = 1;
  localparam int unsigned BIT_DISP_ONOFF  = 0;
  localparam int unsigned BIT_CE_LEVEL    = 0;
  localparam int unsigned BIT_VSYNC_LEVEL = 2;
  localparam int unsigned BIT_GATE_OPEN   = 0;

  // Interrupt status bits
  localparam int unsigned IRQ_GATE_DONE  = 0;
  localparam int unsigned IRQ_CE_CHANGE  = 1;
  localparam int unsigned IRQ_VS_CHANGE  = 2;
  localparam int unsigned IRQ_BAD_GATE   = 3;

  localparam logic [3:0] RST_ZERO = 4'h0;

  typedef enum logic [1:0] {
    PCR_GATE_CLOSE = 2'b00,
    PCR_GATE_OPEN  = 2'b01,
    PCR_GATE_TIMED = 2'b10,
    PCR_GATE_BAD   = 2'b11
  } pcr_gate_e;

  typedef enum logic [1:0] {
    PCR_IRQ_CLK7  = 2'b00,
    PCR_IRQ_CLK8  = 2'b01,
    PCR_IRQ_START = 2'b10,
    PCR_IRQ_STOP  = 2'b11
  } pcr_irqc_e;

  // Timing
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned GATE_WIN_NS   = 1690000;
  localparam int unsigned GATE_WIN_CYC  = GATE_WIN_NS * CLK_MHZ / 1000;
  localparam int unsigned SHIFT_KHZ_0   = 100;
  localparam int unsigned SHIFT_KHZ_1   = 200;
  localparam int unsigned SHIFT_KHZ_2   = 500;
  localparam int unsigned SHIFT_KHZ_3   = 1000;
  localparam int unsigned HALF_DIV_0    = CLK_MHZ * 1000 / (2 * SHIFT_KHZ_0);
  localparam int unsigned HALF_DIV_1    = CLK_MHZ * 1000 / (2 * SHIFT_KHZ_1);
  localparam int unsigned HALF_DIV_2    = CLK_MHZ * 1000 / (2 * SHIFT_KHZ_2);
  localparam int unsigned HALF_DIV_3    = CLK_MHZ * 1000 / (2 * SHIFT_KHZ_3);
  localparam int unsigned CLK7_COUNT    = 7;
  localparam int unsigned CLK8_COUNT    = 8;

endpackage

// [tb/test_peripheral_control_regs.sv]
// Self-checking bench for the peripheral control register bank.
// Assumes pcr_pkg is compiled first; gate window shortened to GATE_N cycles.
`timescale 1ns/1ps

module test_peripheral_control_regs;
  localparam int unsigned GATE_N = 20;
  logic       core_clk, rst, stop_rst, ce_rst, reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [3:0] reg_wdata, reg_rdata, d;
  logic       ce_pin, vsync_pin, ser_clk_tick, ser_start_cond, ser_stop_cond;
  logic       serial_irq, shift_clk, hsync_gate_open, display_transfer_mode;
  logic       onscreen_display_enable, char_rom_bank_bit, irq;
  logic [2:0] stack_ptr;
  int         err_count, cmp_count, cyc;

  pcr_regs #(.GATE_CYCLES(GATE_N), .SP_W(3)) uut (
    .core_clk(core_clk), .rst(rst), .stop_rst(stop_rst), .ce_rst(ce_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ce_pin(ce_pin), .vsync_pin(vsync_pin),
    .ser_clk_tick(ser_clk_tick), .ser_start_cond(ser_start_cond), .ser_stop_cond(ser_stop_cond),
    .serial_irq(serial_irq), .shift_clk(shift_clk), .hsync_gate_open(hsync_gate_open),
    .display_transfer_mode(display_transfer_mode), .onscreen_display_enable(onscreen_display_enable),
    .char_rom_bank_bit(char_rom_bank_bit), .stack_ptr(stack_ptr), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Hang guard: well above the longest divider measurement
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [3:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [3:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic t_regs();
    rd(pcr_pkg::OFF_XFER_EN, d);     chk("xfer reset", d, 4'h0);
    rd(pcr_pkg::OFF_HS_GATE_STS, d); chk("gate sts reset", d, 4'h0);
    wr(pcr_pkg::OFF_XFER_EN, 4'hF);
    rd(pcr_pkg::OFF_XFER_EN, d);     chk("xfer rd", d, 4'h2);
    chk("xfer mode", display_transfer_mode, 1'b1);
    chk("disp on", onscreen_display_enable, 1'b1);
    wr(pcr_pkg::OFF_DISP_ONOFF, 4'hF);
    rd(pcr_pkg::OFF_DISP_ONOFF, d);  chk("disp rd", d, 4'h1);
    chk("disp off", onscreen_display_enable, 1'b0);
    wr(pcr_pkg::OFF_CHARACTER_ROM_BANK, 4'hF);
    rd(pcr_pkg::OFF_CHARACTER_ROM_BANK, d);   chk("bank rd", d, 4'h2);
    chk("bank bit", char_rom_bank_bit, 1'b1);
    wr(pcr_pkg::OFF_STACK_PTR, 4'h5);
    rd(pcr_pkg::OFF_STACK_PTR, d);   chk("sp rd", d, 4'h5);
    chk("sp out", stack_ptr, 3'h5);
    wr(pcr_pkg::OFF_HS_GATE_STS, 4'hF);
    rd(pcr_pkg::OFF_HS_GATE_STS, d); chk("sts ro", d, 4'h0);
    rd(6'h3F, d);                    chk("unmapped", d, 4'h0);
    $display("test regs done");
  endtask

  // Serial registers survive STOP and CE resets, control registers clear
  task automatic t_keep();
    wr(pcr_pkg::OFF_SER_IRQ_TIM, 4'h2);
    wr(pcr_pkg::OFF_XFER_EN, 4'h2);
    @(posedge core_clk) stop_rst <= 1'b1;
    @(posedge core_clk) stop_rst <= 1'b0;
    rd(pcr_pkg::OFF_SER_IRQ_TIM, d); chk("irqtim stop", d, 4'h2);
    rd(pcr_pkg::OFF_XFER_EN, d);     chk("xfer stop", d, 4'h0);
    @(posedge core_clk) ce_rst <= 1'b1;
    @(posedge core_clk) ce_rst <= 1'b0;
    rd(pcr_pkg::OFF_SER_CLK_SEL, d); chk("clksel ce", d, 4'h3);
    $display("test keep done");
  endtask

  task automatic t_gate();
    int n;
    wr(pcr_pkg::OFF_HS_GATE_CTL, 4'h1);
    step(2); chk("gate open", hsync_gate_open, 1'b1);
    rd(pcr_pkg::OFF_HS_GATE_STS, d); chk("sts open", d, 4'h1);
    wr(pcr_pkg::OFF_HS_GATE_CTL, 4'h0);
    step(2); chk("gate closed", hsync_gate_open, 1'b0);
    wr(pcr_pkg::OFF_IRQ_STATUS, 4'hF);
    wr(pcr_pkg::OFF_HS_GATE_CTL, 4'h2);
    step(2);
    n = 0;
    while (hsync_gate_open === 1'b1 && n < 100) begin
      n++;
      step(1);
    end
    chk("window low", n >= GATE_N - 2, 1);
    chk("window high", n <= GATE_N + 1, 1);
    rd(pcr_pkg::OFF_IRQ_STATUS, d);  chk("done flag", d[0], 1'b1);
    wr(pcr_pkg::OFF_HS_GATE_CTL, 4'h3);
    step(2); chk("bad code", hsync_gate_open, 1'b0);
    rd(pcr_pkg::OFF_IRQ_STATUS, d);  chk("bad flag", d[3], 1'b1);
    $display("test gate done");
  endtask

  task automatic t_pins();
    wr(pcr_pkg::OFF_IRQ_STATUS, 4'hF);
    wr(pcr_pkg::OFF_IRQ_MASK, 4'h4);
    @(posedge core_clk) ce_pin <= 1'b1;
    step(6);
    rd(pcr_pkg::OFF_CE_LEVEL, d);    chk("ce high", d, 4'h1);
    chk("masked", irq, 1'b0);
    @(posedge core_clk) vsync_pin <= 1'b1;
    step(6);
    rd(pcr_pkg::OFF_VSYNC_LEVEL, d); chk("vs high", d, 4'h4);
    chk("irq up", irq, 1'b1);
    rd(pcr_pkg::OFF_IRQ_STATUS, d);  chk("status", d[2:1], 2'b11);
    wr(pcr_pkg::OFF_IRQ_STATUS, 4'h4);
    step(2); chk("irq clr", irq, 1'b0);
    @(posedge core_clk) begin ce_pin <= 1'b0; vsync_pin <= 1'b0; end
    step(6);
    rd(pcr_pkg::OFF_CE_LEVEL, d);    chk("ce low", d, 4'h0);
    rd(pcr_pkg::OFF_VSYNC_LEVEL, d); chk("vs low", d, 4'h0);
    $display("test pins done");
  endtask

  task automatic t_sclk();
    int n;
    int half [4] = '{pcr_pkg::HALF_DIV_0, pcr_pkg::HALF_DIV_1, pcr_pkg::HALF_DIV_2, pcr_pkg::HALF_DIV_3};
    for (int c = 0; c < 4; c++) begin
      wr(pcr_pkg::OFF_SER_CLK_SEL, c[3:0]);
      step(2);
      for (int e = 0; e < 2; e++) begin
        d[0] = shift_clk;
        n = 0;
        while (shift_clk === d[0] && n < 3000) begin
          n++;
          step(1);
        end
      end
      chk("half period", n, half[c]);
    end
    $display("test shift clock done");
  endtask

  // Records the tick after which the serial interrupt pulsed; 9 marks the stop, 0 none
  task automatic t_cond(input logic [1:0] code, input bit with_start, input int exp);
    int hit;
    hit = 0;
    wr(pcr_pkg::OFF_SER_IRQ_TIM, {2'b00, code});
    if (with_start) begin
      @(posedge core_clk) ser_start_cond <= 1'b1;
      @(posedge core_clk) ser_start_cond <= 1'b0;
    end
    step(2);
    for (int i = 1; i <= 8; i++) begin
      @(posedge core_clk) ser_clk_tick <= 1'b1;
      @(posedge core_clk) ser_clk_tick <= 1'b0;
      // The pulse stands only in the cycle right after the tick is taken
      #1 if (serial_irq === 1'b1 && hit == 0) hit = i;
    end
    @(posedge core_clk) ser_stop_cond <= 1'b1;
    @(posedge core_clk) ser_stop_cond <= 1'b0;
    #1 if (serial_irq === 1'b1 && hit == 0) hit = 9;
    chk("irq cond", hit, exp);
    $display("test serial cond %0d done", code);
  endtask

  initial begin
    err_count = 0; cmp_count = 0; cyc = 0;
    rst = 1'b1; stop_rst = 1'b0; ce_rst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 6'h00; reg_wdata = 4'h0; ce_pin = 1'b0; vsync_pin = 1'b0;
    ser_clk_tick = 1'b0; ser_start_cond = 1'b0; ser_stop_cond = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    wr(pcr_pkg::OFF_SER_CLK_SEL, 4'h3);
    t_regs();
    t_keep();
    t_gate();
    t_pins();
    t_sclk();
    t_cond(2'b00, 1'b1, 7);
    t_cond(2'b01, 1'b1, 8);
    t_cond(2'b10, 1'b1, 7);
    t_cond(2'b10, 1'b0, 0);
    t_cond(2'b11, 1'b1, 9);
    close_out();
  end
endmodule
